// ===== route_pkg.sv
// shared constants for the routed histogram bank selector
`default_nettype none
package route_pkg;
	// ----------------------------------------
	// memory geometry
	// ----------------------------------------
	localparam int unsigned BLOCK_COUNT = 512;  // histogram blocks in total
	localparam int unsigned BLOCK_W = 9;  // bits of a block number
	localparam int unsigned ROUTE_CH = 4;  // router channels
	localparam int unsigned ROUTE_W = 2;  // bits of a router channel
	localparam int unsigned BIN_W = 12;  // bits of a time bin
	localparam int unsigned RATE_W = 24;  // bits of a rate counter
	localparam logic [ROUTE_W-1:0] ROUTE_ZERO = 2'h0;  // base alignment bits
	localparam logic [RATE_W-1:0] RATE_ZERO = 24'h00_0000;  // counter reset value
	localparam logic [RATE_W-1:0] RATE_ONE = 24'h00_0001;  // counter step
	// ----------------------------------------
	// rate meter source selector
	// ----------------------------------------
	localparam logic [2:0] METER_SUM = 3'h4;  // sum of all routing channels
endpackage
`default_nettype wire

// ===== rate_meter.sv
// one event counter with a gate window, latched at each gate end
`default_nettype none
module rate_meter
	import route_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// events and gate
	input wire logic event_hit,
	input wire logic gate_end,
	// result
	output logic [RATE_W-1:0] rate
);
	logic [RATE_W-1:0] count_r;  // running count of this gate

	// count, restart at gate end; an event at gate end starts the new gate
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= RATE_ZERO;
		end else if (gate_end) begin
			count_r <= event_hit ? RATE_ONE : RATE_ZERO;
		end else if (event_hit) begin
			count_r <= count_r + RATE_ONE;
		end
	end

	// latch the finished gate's total, counting an event at gate end as well
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rate <= RATE_ZERO;
		end else if (gate_end) begin
			rate <= event_hit ? count_r + RATE_ONE : count_r;
		end
	end
endmodule
`default_nettype wire

// ===== routed_histogram_bank_select.sv
// routing logic: steers timed counts to histogram blocks, tags records, feeds rate meters
`default_nettype none
// Overview of operation
// - routed counts go to channel's own block
// - routed collection spans four consecutive blocks of 512
// - base block is first of four, aligned
// - unrouted: all counts into selected block
// - tagged records carry two routing bits
// - all channels share one timing input
// - input rate counts every event always
// - other meters: sum or one channel
// - routing allowed only with router detected
// - only first photon per sync period timed
module routed_histogram_bank_select
	import route_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration
	input wire logic routed_req,
	input wire logic [BLOCK_W-1:0] block_sel,
	input wire logic [2:0] meter_sel,
	input wire logic router_present_pin,
	// timing front end (same clock domain)
	input wire logic sync_tick,
	input wire logic photon_hit,
	input wire logic [BIN_W-1:0] photon_bin,
	input wire logic gate_end,
	// router control port pins
	input wire logic [ROUTE_W-1:0] router_port_a,
	// histogram increment stream
	output logic hist_valid,
	output logic [BLOCK_W-1:0] hist_block,
	output logic [BIN_W-1:0] hist_bin,
	// time tagged record stream
	input wire logic time_tagged_record_mode,
	output logic rec_valid,
	output logic [ROUTE_W-1:0] rec_route,
	output logic [BIN_W-1:0] rec_bin,
	// status
	output logic router_detected,
	output logic routed_active,
	output logic [RATE_W-1:0] input_rate,
	output logic [RATE_W-1:0] meter_rate
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [ROUTE_W-1:0] chan_s1_r;  // first stage, read only by second
	logic [ROUTE_W-1:0] chan_r;  // synchronised channel number
	logic pres_s1_r;  // first stage of presence
	logic pres_r;  // synchronised presence
	logic started_r;  // startup sample taken
	logic taken_r;  // a photon already timed this sync period

	// two flops for the channel and presence pins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_s1_r <= ROUTE_ZERO;
			chan_r <= ROUTE_ZERO;
			pres_s1_r <= 1'b0;
			pres_r <= 1'b0;
		end else begin
			chan_s1_r <= router_port_a;
			chan_r <= chan_s1_r;
			pres_s1_r <= router_present_pin;
			pres_r <= pres_s1_r;
		end
	end

	// ----------------------------------------
	// startup detection and routing enable
	// ----------------------------------------
	// presence caught once after reset, when the synchroniser has settled
	// two delay stages, so the pin has crossed both synchroniser flops first
	logic settle_r;  // first delay stage before sampling
	logic settle2_r;  // second delay stage, presence now settled in pres_r
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_r <= 1'b0;
			settle2_r <= 1'b0;
			started_r <= 1'b0;
			router_detected <= 1'b0;
		end else begin
			settle_r <= 1'b1;
			settle2_r <= settle_r;
			if (settle2_r && !started_r) begin
				started_r <= 1'b1;
				router_detected <= pres_r;
			end
		end
	end

	assign routed_active = routed_req && router_detected;

	// ----------------------------------------
	// block arithmetic
	// ----------------------------------------
	// align a block number to a group of four
	function automatic logic [BLOCK_W-1:0] group_base(input logic [BLOCK_W-1:0] b);
		group_base = {b[BLOCK_W-1:ROUTE_W], ROUTE_ZERO};
	endfunction

	logic [BLOCK_W-1:0] base_blk;  // effective base block
	logic [BLOCK_W-1:0] target_blk;  // block for this count
	// base is forced to a multiple of four while routed
	assign base_blk = routed_active ? group_base(block_sel) : block_sel;
	// routed: base plus channel stays inside the aligned group of four blocks
	assign target_blk = routed_active ? {base_blk[BLOCK_W-1:ROUTE_W], chan_r}
		: base_blk;

	// ----------------------------------------
	// first photon per sync period
	// ----------------------------------------
	logic accept;  // this photon is timed
	// a photon on the sync edge belongs to the new period
	assign accept = photon_hit && (sync_tick || !taken_r);

	// mark the period taken after its first photon; set wins over the sync clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			taken_r <= 1'b0;
		end else if (photon_hit) begin
			taken_r <= 1'b1;
		end else if (sync_tick) begin
			taken_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// histogram and record outputs
	// ----------------------------------------
	// one registered increment per accepted photon outside record mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hist_valid <= 1'b0;
			hist_block <= '0;
			hist_bin <= '0;
		end else begin
			hist_valid <= accept && !time_tagged_record_mode;
			if (accept) begin
				hist_block <= target_blk;
				hist_bin <= photon_bin;
			end
		end
	end

	// tagged records carry the routing bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rec_valid <= 1'b0;
			rec_route <= ROUTE_ZERO;
			rec_bin <= '0;
		end else begin
			rec_valid <= accept && time_tagged_record_mode;
			if (accept) begin
				rec_route <= chan_r;
				rec_bin <= photon_bin;
			end
		end
	end

	// ----------------------------------------
	// rate meters
	// ----------------------------------------
	logic [ROUTE_CH-1:0] chan_hit;  // per-channel events
	logic [RATE_W-1:0] ch_rate [ROUTE_CH];  // per-channel rates
	logic [RATE_W-1:0] sum_rate;  // all-channel accepted rate

	// every event at the shared input, routed or not
	rate_meter u_input (
		.clk(clk),
		.rst_n(rst_n),
		.event_hit(photon_hit),
		.gate_end(gate_end),
		.rate(input_rate)
	);

	rate_meter u_sum (
		.clk(clk),
		.rst_n(rst_n),
		.event_hit(accept),
		.gate_end(gate_end),
		.rate(sum_rate)
	);

	// one meter per routing channel
	genvar gi;
	generate
		for (gi = 0; gi < ROUTE_CH; gi++) begin : g_ch
			assign chan_hit[gi] = accept && (chan_r == ROUTE_W'(gi));
			rate_meter u_ch (
				.clk(clk),
				.rst_n(rst_n),
				.event_hit(chan_hit[gi]),
				.gate_end(gate_end),
				.rate(ch_rate[gi])
			);
		end
	endgenerate

	// meter shows the sum or one selected channel when routed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meter_rate <= RATE_ZERO;
		end else if (routed_active && meter_sel != METER_SUM) begin
			meter_rate <= ch_rate[meter_sel[ROUTE_W-1:0]];
		end else begin
			meter_rate <= sum_rate;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_routed_target: assert property (@(posedge clk) disable iff (!rst_n)
		accept && routed_active && !time_tagged_record_mode |=>
		hist_valid && hist_block == {$past(block_sel[BLOCK_W-1:ROUTE_W]), $past(chan_r)})
		else $error("routed count went to wrong block");
	a_group_aligned: assert property (@(posedge clk) disable iff (!rst_n)
		routed_active |-> base_blk[ROUTE_W-1:0] == ROUTE_ZERO)
		else $error("routed base not aligned to four");
	a_plain_block: assert property (@(posedge clk) disable iff (!rst_n)
		accept && !routed_active && !time_tagged_record_mode |=>
		hist_block == $past(block_sel))
		else $error("unrouted count left selected block");
	a_record_route: assert property (@(posedge clk) disable iff (!rst_n)
		accept && time_tagged_record_mode |=> rec_valid && rec_route == $past(chan_r))
		else $error("record route bits wrong");
	a_first_only: assert property (@(posedge clk) disable iff (!rst_n)
		photon_hit ##1 (photon_hit && !sync_tick) |-> !accept)
		else $error("second photon in period accepted");
	a_late_drop: assert property (@(posedge clk) disable iff (!rst_n)
		photon_hit && taken_r && !sync_tick |=> !hist_valid && !rec_valid)
		else $error("late photon produced an output");
	a_route_gate: assert property (@(posedge clk) disable iff (!rst_n)
		accept && !router_detected && !time_tagged_record_mode |=>
		hist_block == $past(block_sel))
		else $error("routing without router");
	a_detect_hold: assert property (@(posedge clk) disable iff (!rst_n)
		started_r |=> $stable(router_detected))
		else $error("router presence changed after startup");
	a_group_span: assert property (@(posedge clk) disable iff (!rst_n)
		accept && routed_active && !time_tagged_record_mode |=>
		hist_block - $past(base_blk) < BLOCK_W'(ROUTE_CH))
		else $error("routed block outside group of four");
	a_meter_sum: assert property (@(posedge clk) disable iff (!rst_n)
		!routed_active ##1 1'b1 |-> meter_rate == $past(sum_rate))
		else $error("meter not showing sum");
	a_no_dual: assert property (@(posedge clk) disable iff (!rst_n)
		!(hist_valid && rec_valid))
		else $error("count in both streams");
	c_routed: cover property (@(posedge clk) disable iff (!rst_n) accept && routed_active);
	c_plain: cover property (@(posedge clk) disable iff (!rst_n) accept && !routed_active);
	c_record: cover property (@(posedge clk) disable iff (!rst_n) rec_valid);
	c_drop: cover property (@(posedge clk) disable iff (!rst_n) photon_hit && taken_r);
endmodule
`default_nettype wire

// ===== router_model.sv
// behavioural model of the four-input detector router on the control port
`default_nettype none
module router_model
	import route_pkg::*;
(
	// clock
	input wire logic clk,
	// detector inputs and cable presence
	input wire logic [3:0] det,
	input wire logic attach,
	// control port and shared timing output
	output logic [ROUTE_W-1:0] router_port_a,
	output logic photon_hit,
	output logic present_pin,
	output logic activity
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] seen; // detectors sampled at the edge
	logic [1:0] wait_cnt; // edges left before the timing pulse
	// inputs in a forbidden level/edge state; any one would block every channel
	logic [3:0] locked = 4'h0;
	// inputs fed from a constant_fraction_discriminator, and inputs set to NIM
	logic [3:0] cfd_fed = 4'h0;
	logic [3:0] nim_set = 4'hf;
	assign present_pin = attach;
	assign activity = |det;
	initial begin
		router_port_a = 2'h0;
		photon_hit = 1'b0;
		wait_cnt = 2'h0;
	end
	// channel code leaves first so it is settled before the timing pulse
	always @(posedge clk) begin
		seen = det;
		#1;
		photon_hit = (wait_cnt == 2'h1);
		if (wait_cnt != 2'h0) begin
			wait_cnt = wait_cnt - 2'h1;
		end
		// coincident detectors are thrown away, only a lone hit is passed
		if ($onehot(seen) && locked == 4'h0 && (cfd_fed & ~nim_set) == 4'h0) begin
			router_port_a = seen[1] ? 2'h1 : seen[2] ? 2'h2 : seen[3] ? 2'h3 : 2'h0;
			wait_cnt = 2'h2;
		end
	end
endmodule
`default_nettype wire

// ===== routed_histogram_bank_select_tb.sv
// self-checking bench: router model feeding the bank selector
`default_nettype none
module routed_histogram_bank_select_tb
	import route_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// stimulus and wiring
	// ----------------------------------------
	logic clk = 1'b0, rst_n = 1'b0, routed_req = 1'b0, sync_tick = 1'b0, gate_end = 1'b0;
	logic ttr = 1'b0, attach = 1'b1, photon_hit, present, hist_valid, rec_valid, detected, active;
	logic [3:0] det = 4'h0;
	logic [2:0] meter_sel = METER_SUM;
	logic [BLOCK_W-1:0] block_sel = 9'h000, hist_block;
	logic [BIN_W-1:0] photon_bin = 12'h000, hist_bin, rec_bin;
	logic [ROUTE_W-1:0] port, rec_route;
	logic [RATE_W-1:0] input_rate, meter_rate;
	logic [31:0] seed = 32'h0000_7674; // random source state
	logic [21:0] notes[$]; // expected {record, block or route, bin}
	int failures = 0, n_tests = 0;
	always #12.5 clk = ~clk;
	router_model router_model_i (.clk(clk), .det(det), .attach(attach), .router_port_a(port),
		.photon_hit(photon_hit), .present_pin(present), .activity());
	routed_histogram_bank_select routed_histogram_bank_select_i (.clk(clk), .rst_n(rst_n),
		.routed_req(routed_req), .block_sel(block_sel), .meter_sel(meter_sel),
		.router_present_pin(present), .sync_tick(sync_tick), .photon_hit(photon_hit),
		.photon_bin(photon_bin), .gate_end(gate_end), .router_port_a(port),
		.hist_valid(hist_valid), .hist_block(hist_block), .hist_bin(hist_bin),
		.time_tagged_record_mode(ttr), .rec_valid(rec_valid), .rec_route(rec_route),
		.rec_bin(rec_bin), .router_detected(detected), .routed_active(active),
		.input_rate(input_rate), .meter_rate(meter_rate));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one detector pulse; fresh opens a new sync period, else it is a late photon
	task automatic fire(input int ch, input bit fresh);
		seed = lfsr(seed);
		photon_bin = seed[11:0];
		det = 4'h1 << ch;
		sync_tick = fresh;
		if (fresh && ttr) notes.push_back({1'b1, 7'h00, ch[1:0], seed[11:0]});
		else if (fresh) notes.push_back({1'b0, (routed_req && attach) ?
			{block_sel[8:2], ch[1:0]} : block_sel, seed[11:0]});
		tick(1);
		det = 4'h0;
		sync_tick = 1'b0;
		tick(6);
	endtask
	task automatic gate();
		gate_end = 1'b1;
		tick(1);
		gate_end = 1'b0;
		tick(2);
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// result watcher: every output pulse takes the oldest note
	// ----------------------------------------
	always @(negedge clk) begin
		if (hist_valid === 1'b1 || rec_valid === 1'b1) begin
			if (notes.size() == 0) chk(24'h00_0000, 24'h00_0001);
			else if (rec_valid) chk({3'h1, 7'h00, rec_route, rec_bin}, notes.pop_front());
			else chk({3'h0, hist_block, hist_bin}, notes.pop_front());
		end
	end
	initial begin
		tick(4000);
		failures++;
		wrap_up();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		tick(3);
		rst_n = 1'b1;
		tick(5);
		chk(detected, 1'b1);
		routed_req = 1'b1;
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			block_sel = seed[8:0];
			fire(i % 4, 1'b1);
		end
		chk(active, 1'b1);
		routed_req = 1'b0;
		for (int i = 0; i < 4; i++) fire(i, 1'b1);
		$display("test block steering done");
		ttr = 1'b1;
		routed_req = 1'b1;
		for (int i = 0; i < 4; i++) fire(3 - i, 1'b1);
		ttr = 1'b0;
		$display("test record routing done");
		// late photon in the same period is dropped yet still seen at the input
		gate();
		fire(2, 1'b1);
		fire(1, 1'b0);
		gate();
		chk(input_rate, 24'h00_0002);
		for (int s = 0; s < 5; s++) begin
			meter_sel = s[2:0];
			fire(1, 1'b1);
			fire(1, 1'b1);
			fire(1, 1'b1);
			fire(2, 1'b1);
			gate();
			chk(meter_rate, 24'(s == 1 ? 3 : s == 2 ? 1 : s == 4 ? 4 : 0));
		end
		$display("test rate meters done");
		// without a router at startup the routing request has no effect
		attach = 1'b0;
		rst_n = 1'b0;
		tick(3);
		rst_n = 1'b1;
		tick(5);
		chk(detected, 1'b0);
		chk(active, 1'b0);
		fire(3, 1'b1);
		chk(24'(notes.size()), 24'h00_0000);
		$display("test absent router done");
		wrap_up();
	end
endmodule
`default_nettype wire
